// ==== rtl/spi_port_pkg.sv ====
package spi_port_pkg;

  // Transfer engine states, shared by both ends
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_MSHIFT = 3'b010,
    ST_SSHIFT = 3'b100
  } xfer_state_t;

  // Device register addresses and fields
  localparam logic [1:0] ADDR_CTRL   = 2'h0;
  localparam logic [1:0] ADDR_STATUS = 2'h1;
  localparam logic [1:0] ADDR_DATA   = 2'h2;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam int C_IRQ_EN  = 7;
  localparam int C_EN      = 6;
  localparam int C_ORDER   = 5;
  localparam int C_MASTER  = 4;
  localparam int C_CLOCK_POLARITY    = 3;
  localparam int C_CLOCK_PHASE    = 2;
  localparam int C_RATE_LO = 0;
  localparam int S_FLAG    = 7;
  localparam int S_WRITE_COLLISION_FLAG    = 6;
  localparam int S_DBL     = 0;

  // Pin slots in the device's synchroniser vector
  localparam int PIN_SCK  = 0;
  localparam int PIN_MOSI = 1;
  localparam int PIN_MISO = 2;
  localparam int PIN_SS   = 3;
  localparam logic [3:0] PIN_RESET = 4'h8;

  // Half SCK period in clocks, indexed by {double, rate}
  localparam logic [6:0] HALF_TABLE [0:7] = '{7'h02, 7'h08, 7'h20, 7'h40,
                                             7'h01, 7'h04, 7'h10, 7'h20};
  localparam logic [4:0] LAST_EDGE = 5'h0f;
  localparam logic [3:0] LAST_BIT  = 4'h7;

  // Slave SCK phases must exceed this many clocks
  localparam logic [7:0] SLAVE_MIN_PHASE = 8'h02;

  // Partner register map and fields
  localparam logic [3:0]  P_CTRL     = 4'h0;
  localparam logic [3:0]  P_TX       = 4'h4;
  localparam logic [3:0]  P_RX       = 4'h8;
  localparam logic [3:0]  P_STAT     = 4'hc;
  localparam logic [31:0] PCTRL_RESET = 32'h0000_0810;
  localparam int PC_EN   = 0;
  localparam int PC_CLOCK_POLARITY = 1;
  localparam int PC_CLOCK_PHASE = 2;
  localparam int PC_LSB  = 3;
  localparam int PC_SEL  = 4;
  localparam int PS_BUSY = 0;
  localparam int PS_DONE = 1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Serial bit helpers for either bit order
  function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic lsb);
    return lsb ? {b, d[7:1]} : {d[6:0], b};
  endfunction : shift_in

  function automatic logic [7:0] shift_out(input logic [7:0] d, input logic lsb);
    return lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
  endfunction : shift_out

  function automatic logic out_bit(input logic [7:0] d, input logic lsb);
    return lsb ? d[0] : d[7];
  endfunction : out_bit

endpackage : spi_port_pkg

// ==== rtl/spi_link_if.sv ====
`timescale 1ns/1ps
interface spi_link_if;
  logic dev_sck_o;
  logic dev_sck_oe;
  logic dev_mosi_o;
  logic dev_mosi_oe;
  logic dev_miso_o;
  logic dev_miso_oe;
  logic dev_ss_n_o;
  logic dev_ss_n_oe;
  logic part_sck_o;
  logic part_sck_oe;
  logic part_mosi_o;
  logic part_mosi_oe;
  logic part_miso_o;
  logic part_miso_oe;
  logic part_ss_n_o;
  logic part_ss_n_oe;
  logic sck;
  logic mosi;
  logic miso;
  logic ss_n;

  // Wire levels; an undriven line floats high through a pull-up
  assign sck  = dev_sck_oe  ? dev_sck_o  : (part_sck_oe  ? part_sck_o  : 1'b1);
  assign mosi = dev_mosi_oe ? dev_mosi_o : (part_mosi_oe ? part_mosi_o : 1'b1);
  assign miso = dev_miso_oe ? dev_miso_o : (part_miso_oe ? part_miso_o : 1'b1);
  assign ss_n = dev_ss_n_oe ? dev_ss_n_o : (part_ss_n_oe ? part_ss_n_o : 1'b1);

  modport dev (output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
               output dev_miso_o, dev_miso_oe, dev_ss_n_o, dev_ss_n_oe,
               input sck, mosi, miso, ss_n);
  modport part (output part_sck_o, part_sck_oe, part_mosi_o, part_mosi_oe,
                output part_miso_o, part_miso_oe, part_ss_n_o, part_ss_n_oe,
                input sck, mosi, miso, ss_n);
endinterface : spi_link_if

// ==== rtl/sync2.sv ====
`timescale 1ns/1ps
module sync2 #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] out;
  } sync_state_t;

  sync_state_t s_q;
  sync_state_t s_d;

  if (W < 1)
  begin : g_check
    $error("sync2 width must be at least one");
  end

  // First stage feeds only the second
  always_comb
  begin
    s_d.meta = d;
    s_d.out  = s_q.meta;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s_q <= {INIT, INIT};
    else
      s_q <= s_d;
  end

  assign q = s_q.out;

endmodule : sync2

// ==== rtl/spi_port_device.sv ====
`timescale 1ns/1ps
// Behaviour
// [RL1] Master data write starts eight-bit shift
// [RL2] Master stops clock, sets done, maybe interrupt
// [RL3] Software drives slave select in master mode
// [RL4] Master lowers select to start, raises after
// [RL5] MOSI master to slave, MISO back, master clocks
// [RL6] Software writes next byte or raises select
// [RL7] Unselected slave idles with MISO released
// [RL8] Slave byte complete sets done, maybe interrupt
// [RL9] Last received byte kept in receive buffer
// [RL10] Single transmit buffer; write only when idle
// [RL11] Software reads byte before next one completes
// [RL12] Slave SCK phases exceed two clocks, sampled
// [RL13] Enable forces pin directions per mode
// [RL14] Power reduction held clear to operate
// [RL15] Bit order selects LSB or MSB first
// [RL16] Double rate gives clock divided by two
// [RL17] Master divides by 4/16/64/128, halved doubled
// [RL18] Polarity sets idle level, phase sample edge
// [RL19] Busy write flags collision; status-then-data clears
// [RL20] Low select on master input forces slave
// [RL21] Eight sampled bits complete every transfer
module spi_port_device (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [1:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  output logic            irq_req,
  input  wire logic       power_reduce,
  input  wire logic       dir_mosi,
  input  wire logic       dir_miso,
  input  wire logic       dir_sck,
  input  wire logic       dir_ss,
  input  wire logic       ss_level,
  spi_link_if.dev         link
);

  typedef struct packed {
    spi_port_pkg::xfer_state_t st;
    logic [7:0]                ctrl;
    logic                      flag;
    logic                      write_collision_flag;
    logic                      dbl;
    logic                      armed;
    logic [7:0]                tx;
    logic [7:0]                rx;
    logic [7:0]                rxbuf;
    logic [3:0]                bits;
    logic [4:0]                edges;
    logic [6:0]                div;
    logic                      sck;
    logic                      sck_prev;
    logic [7:0]                rdata;
    logic                      irq;
    logic [3:0]                pin_o;
    logic [3:0]                pin_oe;
  } dev_state_t;

  localparam dev_state_t DEV_RESET = '{st: spi_port_pkg::ST_IDLE,
                                       ctrl: spi_port_pkg::CTRL_RESET,
                                       default: '0};

  dev_state_t s_q;
  dev_state_t s_d;
  logic [3:0] pin_q;
  logic       en;
  logic       mst;
  logic       lsb;
  logic       clock_polarity;
  logic       clock_phase;
  logic [1:0] rate;
  logic       data_acc;
  logic       sck_in;
  logic       ss_in;

  // Every pin is foreign to this clock, so two flops first
  sync2 #(
    .W    (4),
    .INIT (spi_port_pkg::PIN_RESET)
  ) u_pin_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     ({link.ss_n, link.miso, link.mosi, link.sck}),
    .q     (pin_q)
  );

  // Reload value of the half-period down counter
  function automatic logic [6:0] half_load(input logic dbl, input logic [1:0] r);
    return spi_port_pkg::HALF_TABLE[{dbl, r}] - 7'h01;
  endfunction : half_load

  // Current configuration
  assign en       = s_q.ctrl[spi_port_pkg::C_EN] & ~power_reduce; // RL14
  assign mst      = s_q.ctrl[spi_port_pkg::C_MASTER];
  assign lsb      = s_q.ctrl[spi_port_pkg::C_ORDER];
  assign clock_polarity     = s_q.ctrl[spi_port_pkg::C_CLOCK_POLARITY];
  assign clock_phase     = s_q.ctrl[spi_port_pkg::C_CLOCK_PHASE];
  assign rate     = s_q.ctrl[spi_port_pkg::C_RATE_LO +: 2];
  assign data_acc = (reg_wr | reg_rd) & (reg_addr == spi_port_pkg::ADDR_DATA);
  assign sck_in   = pin_q[spi_port_pkg::PIN_SCK];
  assign ss_in    = pin_q[spi_port_pkg::PIN_SS];

  // Next state; clears come first so hardware sets win
  always_comb
  begin
    logic n_on;
    logic n_mst;
    logic lead;
    n_on  = 1'b0;
    n_mst = 1'b0;
    lead  = 1'b0;
    s_d   = s_q;
    s_d.sck_prev = sck_in;
    if (data_acc && s_q.armed)
    begin
      s_d.flag  = 1'b0; // RL19
      s_d.write_collision_flag  = 1'b0;
      s_d.armed = 1'b0;
    end
    if (reg_wr && reg_addr == spi_port_pkg::ADDR_CTRL)
      s_d.ctrl = reg_wdata;
    if (reg_wr && reg_addr == spi_port_pkg::ADDR_STATUS)
      s_d.dbl = reg_wdata[spi_port_pkg::S_DBL];

    // Shift engine
    case (s_q.st)
      spi_port_pkg::ST_MSHIFT:
      begin
        if (!en || !mst)
          s_d.st = spi_port_pkg::ST_IDLE;
        else if (s_q.div != 7'h00)
          s_d.div = s_q.div - 7'h01;
        else
        begin
          s_d.div   = half_load(s_q.dbl, rate); // RL16 RL17
          s_d.sck   = ~s_q.sck; // RL5
          s_d.edges = s_q.edges + 5'h01;
          if (s_q.edges[0] == clock_phase) // RL18
          begin
            s_d.rx   = spi_port_pkg::shift_in(s_q.rx, pin_q[spi_port_pkg::PIN_MISO], lsb);
            s_d.bits = s_q.bits + 4'h1;
          end
          else if (s_q.bits != 4'h0)
            s_d.tx = spi_port_pkg::shift_out(s_q.tx, lsb); // RL15
          if (s_q.edges == spi_port_pkg::LAST_EDGE)
          begin
            s_d.st    = spi_port_pkg::ST_IDLE; // RL2
            s_d.rxbuf = s_d.rx; // RL9 RL11
            s_d.flag  = 1'b1;
          end
        end
      end
      spi_port_pkg::ST_IDLE, spi_port_pkg::ST_SSHIFT:
      begin
        if (!en || mst)
          s_d.st = spi_port_pkg::ST_IDLE;
        else if (ss_in)
        begin
          // Deselect drops any partial byte
          s_d.st   = spi_port_pkg::ST_IDLE; // RL7
          s_d.bits = 4'h0;
          s_d.rx   = 8'h00;
        end
        else if (sck_in != s_q.sck_prev) // RL12
        begin
          lead = (sck_in != clock_polarity);
          if (lead != clock_phase) // RL18
          begin
            s_d.rx = spi_port_pkg::shift_in(s_q.rx, pin_q[spi_port_pkg::PIN_MOSI], lsb);
            s_d.st = spi_port_pkg::ST_SSHIFT;
            if (s_q.bits == spi_port_pkg::LAST_BIT) // RL21
            begin
              s_d.st    = spi_port_pkg::ST_IDLE; // RL8
              s_d.bits  = 4'h0;
              s_d.rxbuf = s_d.rx; // RL9 RL11
              s_d.flag  = 1'b1;
            end
            else
              s_d.bits = s_q.bits + 4'h1;
          end
          else if (s_q.bits != 4'h0)
            s_d.tx = spi_port_pkg::shift_out(s_q.tx, lsb); // RL15
        end
      end
      default:
        s_d.st = spi_port_pkg::ST_IDLE;
    endcase

    // Data write: load when idle, otherwise collide
    if (reg_wr && reg_addr == spi_port_pkg::ADDR_DATA && en)
    begin
      if (s_q.st != spi_port_pkg::ST_IDLE)
        s_d.write_collision_flag = 1'b1; // RL10 RL19
      else
      begin
        s_d.tx = reg_wdata;
        if (mst)
        begin
          s_d.st    = spi_port_pkg::ST_MSHIFT; // RL1
          s_d.div   = half_load(s_q.dbl, rate);
          s_d.edges = 5'h00;
          s_d.bits  = 4'h0;
          s_d.sck   = clock_polarity;
        end
      end
    end

    // Another master selected us; avoid driving against it
    if (en && mst && !dir_ss && !ss_in)
    begin
      s_d.ctrl[spi_port_pkg::C_MASTER] = 1'b0; // RL20
      s_d.flag = 1'b1;
      s_d.st   = spi_port_pkg::ST_IDLE;
    end

    // Register reads, one cycle latency
    if (reg_rd)
    begin
      s_d.rdata = 8'h00;
      case (reg_addr)
        spi_port_pkg::ADDR_CTRL:
          s_d.rdata = s_q.ctrl;
        spi_port_pkg::ADDR_STATUS:
        begin
          s_d.rdata[spi_port_pkg::S_FLAG] = s_q.flag;
          s_d.rdata[spi_port_pkg::S_WRITE_COLLISION_FLAG] = s_q.write_collision_flag;
          s_d.rdata[spi_port_pkg::S_DBL]  = s_q.dbl;
          if (s_q.flag || s_q.write_collision_flag)
            s_d.armed = 1'b1; // RL19
        end
        spi_port_pkg::ADDR_DATA:
          s_d.rdata = s_q.rxbuf;
        default:
          s_d.rdata = 8'h00;
      endcase
    end

    // Pins and interrupt, all registered
    if (s_d.st != spi_port_pkg::ST_MSHIFT)
      s_d.sck = s_d.ctrl[spi_port_pkg::C_CLOCK_POLARITY]; // RL18
    n_on  = s_d.ctrl[spi_port_pkg::C_EN] & ~power_reduce;
    n_mst = s_d.ctrl[spi_port_pkg::C_MASTER];
    s_d.irq = s_d.flag & s_d.ctrl[spi_port_pkg::C_IRQ_EN]; // RL2 RL8
    s_d.pin_o[spi_port_pkg::PIN_SCK]  = s_d.sck;
    s_d.pin_o[spi_port_pkg::PIN_MOSI] = spi_port_pkg::out_bit(s_d.tx, s_d.ctrl[spi_port_pkg::C_ORDER]);
    s_d.pin_o[spi_port_pkg::PIN_MISO] = spi_port_pkg::out_bit(s_d.tx, s_d.ctrl[spi_port_pkg::C_ORDER]);
    s_d.pin_o[spi_port_pkg::PIN_SS]   = ss_level; // RL3
    s_d.pin_oe[spi_port_pkg::PIN_SCK]  = n_on & n_mst & dir_sck; // RL13
    s_d.pin_oe[spi_port_pkg::PIN_MOSI] = n_on & n_mst & dir_mosi;
    s_d.pin_oe[spi_port_pkg::PIN_MISO] = n_on & ~n_mst & dir_miso & ~ss_in; // RL7
    s_d.pin_oe[spi_port_pkg::PIN_SS]   = n_on & n_mst & dir_ss;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s_q <= DEV_RESET;
    else
      s_q <= s_d;
  end

  assign reg_rdata        = s_q.rdata;
  assign irq_req          = s_q.irq;
  assign link.dev_sck_o   = s_q.pin_o[spi_port_pkg::PIN_SCK];
  assign link.dev_sck_oe  = s_q.pin_oe[spi_port_pkg::PIN_SCK];
  assign link.dev_mosi_o  = s_q.pin_o[spi_port_pkg::PIN_MOSI];
  assign link.dev_mosi_oe = s_q.pin_oe[spi_port_pkg::PIN_MOSI];
  assign link.dev_miso_o  = s_q.pin_o[spi_port_pkg::PIN_MISO];
  assign link.dev_miso_oe = s_q.pin_oe[spi_port_pkg::PIN_MISO];
  assign link.dev_ss_n_o  = s_q.pin_o[spi_port_pkg::PIN_SS];
  assign link.dev_ss_n_oe = s_q.pin_oe[spi_port_pkg::PIN_SS];

endmodule : spi_port_device

// ==== rtl/spi_partner.sv ====
`timescale 1ns/1ps
module spi_partner #(
  parameter int ADDR_W = 4
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              wvalid,
  output logic                   wready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  output logic                   bvalid,
  input  wire logic              bready,
  output logic      [1:0]        bresp,
  input  wire logic              arvalid,
  output logic                   arready,
  input  wire logic [ADDR_W-1:0] araddr,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic      [31:0]       rdata,
  output logic      [1:0]        rresp,
  spi_link_if.part               link
);

  typedef struct packed {
    spi_port_pkg::xfer_state_t st;
    logic [31:0]               ctrl;
    logic                      done;
    logic [7:0]                tx;
    logic [7:0]                rx;
    logic [7:0]                rxbuf;
    logic [3:0]                bits;
    logic [4:0]                edges;
    logic [7:0]                div;
    logic                      sck;
    logic                      awready;
    logic [ADDR_W-1:0]         waddr;
    logic                      wready;
    logic [31:0]               wdata;
    logic [3:0]                wstrb;
    logic                      bvalid;
    logic [1:0]                bresp;
    logic                      arready;
    logic                      rvalid;
    logic [31:0]               rdata;
    logic [1:0]                rresp;
    logic                      mosi;
    logic                      ss_n;
    logic                      oe;
  } part_state_t;

  localparam part_state_t PART_RESET = '{st: spi_port_pkg::ST_IDLE,
                                         ctrl: spi_port_pkg::PCTRL_RESET,
                                         awready: 1'b1, wready: 1'b1,
                                         arready: 1'b1, ss_n: 1'b1,
                                         default: '0};

  part_state_t s_q;
  part_state_t s_d;
  logic        miso_q;

  if (ADDR_W < 4)
  begin : g_check
    $error("spi_partner address must hold at least four bits");
  end

  sync2 #(
    .W    (1),
    .INIT (1'b0)
  ) u_miso_sync (
    .clock (clock),
    .rst_n (rst_n),
    .d     (link.miso),
    .q     (miso_q)
  );

  // Half period never drops to the slave's sampling limit
  function automatic logic [7:0] half_load(input logic [31:0] c);
    logic [7:0] h;
    h = c[15:8];
    if (h <= spi_port_pkg::SLAVE_MIN_PHASE)
      h = spi_port_pkg::SLAVE_MIN_PHASE + 8'h01; // RL12
    return h - 8'h01;
  endfunction : half_load

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return ((a >> 4) == '0) && (a[1:0] == 2'b00);
  endfunction : mapped

  always_comb
  begin
    logic [31:0] m;
    m   = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
    s_d = s_q;
    // Write address and data, taken in either order
    if (awvalid && s_q.awready)
    begin
      s_d.awready = 1'b0;
      s_d.waddr   = awaddr;
    end
    if (wvalid && s_q.wready)
    begin
      s_d.wready = 1'b0;
      s_d.wdata  = wdata;
      s_d.wstrb  = wstrb;
    end
    if (s_q.bvalid && bready)
    begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end
    if (!s_q.awready && !s_q.wready && !s_q.bvalid)
    begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = mapped(s_q.waddr) ? spi_port_pkg::RESP_OKAY : spi_port_pkg::RESP_SLVERR;
      if (mapped(s_q.waddr))
      begin
        case (s_q.waddr[3:0])
          spi_port_pkg::P_CTRL:
            s_d.ctrl = (s_q.ctrl & ~m) | (s_q.wdata & m);
          spi_port_pkg::P_TX:
            if (s_q.wstrb[0] && s_q.st == spi_port_pkg::ST_IDLE && s_q.ctrl[spi_port_pkg::PC_EN])
            begin
              s_d.tx    = s_q.wdata[7:0];
              s_d.st    = spi_port_pkg::ST_MSHIFT;
              s_d.div   = half_load(s_q.ctrl);
              s_d.edges = 5'h00;
              s_d.bits  = 4'h0;
            end
          spi_port_pkg::P_STAT:
            if (s_q.wstrb[0] && s_q.wdata[spi_port_pkg::PS_DONE])
              s_d.done = 1'b0;
          default:
            s_d.bresp = spi_port_pkg::RESP_OKAY;
        endcase
      end
    end

    // Master engine; done set after the clear so it wins
    if (s_q.st == spi_port_pkg::ST_MSHIFT)
    begin
      if (!s_q.ctrl[spi_port_pkg::PC_EN])
        s_d.st = spi_port_pkg::ST_IDLE;
      else if (s_q.div != 8'h00)
        s_d.div = s_q.div - 8'h01;
      else
      begin
        s_d.div   = half_load(s_q.ctrl);
        s_d.sck   = ~s_q.sck; // RL5
        s_d.edges = s_q.edges + 5'h01;
        if (s_q.edges[0] == s_q.ctrl[spi_port_pkg::PC_CLOCK_PHASE]) // RL18
        begin
          s_d.rx   = spi_port_pkg::shift_in(s_q.rx, miso_q, s_q.ctrl[spi_port_pkg::PC_LSB]);
          s_d.bits = s_q.bits + 4'h1;
        end
        else if (s_q.bits != 4'h0)
          s_d.tx = spi_port_pkg::shift_out(s_q.tx, s_q.ctrl[spi_port_pkg::PC_LSB]);
        if (s_q.edges == spi_port_pkg::LAST_EDGE)
        begin
          s_d.st    = spi_port_pkg::ST_IDLE;
          s_d.rxbuf = s_d.rx;
          s_d.done  = 1'b1;
        end
      end
    end
    if (s_d.st != spi_port_pkg::ST_MSHIFT)
      s_d.sck = s_d.ctrl[spi_port_pkg::PC_CLOCK_POLARITY]; // RL18

    // Read channel
    if (s_q.rvalid && rready)
    begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end
    if (arvalid && s_q.arready)
    begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rdata   = 32'h0000_0000;
      s_d.rresp   = mapped(araddr) ? spi_port_pkg::RESP_OKAY : spi_port_pkg::RESP_SLVERR;
      if (mapped(araddr))
      begin
        case (araddr[3:0])
          spi_port_pkg::P_CTRL:
            s_d.rdata = s_q.ctrl;
          spi_port_pkg::P_RX:
            s_d.rdata[7:0] = s_q.rxbuf;
          spi_port_pkg::P_STAT:
          begin
            s_d.rdata[spi_port_pkg::PS_BUSY] = (s_q.st == spi_port_pkg::ST_MSHIFT);
            s_d.rdata[spi_port_pkg::PS_DONE] = s_q.done;
          end
          default:
            s_d.rdata = 32'h0000_0000;
        endcase
      end
    end

    // Select is software's; lowered before and raised after a packet
    s_d.ss_n = s_d.ctrl[spi_port_pkg::PC_SEL]; // RL4
    s_d.oe   = s_d.ctrl[spi_port_pkg::PC_EN];
    s_d.mosi = spi_port_pkg::out_bit(s_d.tx, s_d.ctrl[spi_port_pkg::PC_LSB]);
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      s_q <= PART_RESET;
    else
      s_q <= s_d;
  end

  assign awready           = s_q.awready;
  assign wready            = s_q.wready;
  assign bvalid            = s_q.bvalid;
  assign bresp             = s_q.bresp;
  assign arready           = s_q.arready;
  assign rvalid            = s_q.rvalid;
  assign rdata             = s_q.rdata;
  assign rresp             = s_q.rresp;
  assign link.part_sck_o   = s_q.sck;
  assign link.part_sck_oe  = s_q.oe;
  assign link.part_mosi_o  = s_q.mosi;
  assign link.part_mosi_oe = s_q.oe;
  assign link.part_ss_n_o  = s_q.ss_n;
  assign link.part_ss_n_oe = s_q.oe;
  assign link.part_miso_o  = 1'b0; // Partner is master only, never drives MISO
  assign link.part_miso_oe = 1'b0;

endmodule : spi_partner

// ==== testbench/spi_port_assertions.sv ====
`timescale 1ns/1ps
module spi_port_assertions (
  input logic clock,
  input logic rst_n,
  input logic dev_sck_oe,
  input logic dev_mosi_oe,
  input logic dev_miso_oe,
  input logic part_sck_o,
  input logic part_sck_oe,
  input logic part_miso_oe,
  input logic ss_n
);
  // One clock domain throughout
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Pin ownership; the sync delay is why release gets a window
  chk_slave_pins_in: assert property (dev_miso_oe |-> !dev_sck_oe && !dev_mosi_oe)
    else $error("slave drives sck or mosi");
  chk_miso_idle: assert property (ss_n [*5] |-> !dev_miso_oe)
    else $error("miso driven unselected");
  chk_miso_release: assert property ($rose(ss_n) |-> ##[1:6] !dev_miso_oe)
    else $error("miso not released");
  chk_miso_on_select: assert property ($rose(dev_miso_oe) |-> !ss_n)
    else $error("miso enabled unselected");
  chk_sck_one_driver: assert property (!(dev_sck_oe && part_sck_oe))
    else $error("two sck drivers");
  chk_master_no_miso: assert property (!part_miso_oe)
    else $error("master drives miso");
  // Far-end clock shape
  chk_sck_phase_len: assert property
    (part_sck_oe && $changed(part_sck_o) |=> $stable(part_sck_o) [*2])
    else $error("sck phase too short");
  chk_sck_idle_level: assert property
    (part_sck_oe && ss_n && $past(ss_n) |-> $stable(part_sck_o))
    else $error("sck moved between frames");
  // Main scenarios reached
  cover property ($rose(dev_sck_oe));
  cover property ($rose(dev_miso_oe));
  cover property (part_sck_oe && $fell(ss_n));
endmodule : spi_port_assertions

// ==== testbench/tb_spi_master_slave_port.sv ====
`timescale 1ns/1ps
module tb_spi_master_slave_port;
  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  logic [1:0]  ra = 2'h0;
  logic        wr = 1'h0, rd = 1'h0, awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic [7:0]  wd = 8'h00, rdo, cap, td;
  logic [3:0]  dir = 4'hb, aa = 4'h0;
  logic [31:0] ad = 32'h0, rdat, r;
  logic [1:0]  rsp, rs, bsp;
  logic        irq, awr, wrd, bv, arr, rv, sp, smp, lsb, pr = 1'h0;
  int          errors = 0, n_tests = 0, cyc = 0, nt, span, gap, h, k;
  int          dv [4] = '{4, 16, 64, 128};
  spi_link_if link ();
  spi_port_device u_spi_port_device (.clock(clock), .rst_n(rst_n), .reg_addr(ra), .reg_wr(wr),
    .reg_rd(rd), .reg_wdata(wd), .reg_rdata(rdo), .irq_req(irq), .power_reduce(pr),
    .dir_mosi(dir[3]), .dir_miso(dir[2]), .dir_sck(dir[1]), .dir_ss(dir[0]),
    .ss_level(1'h0), .link(link.dev));
  spi_partner u_spi_partner (.clock(clock), .rst_n(rst_n), .awvalid(awv), .awready(awr),
    .awaddr(aa), .wvalid(wv), .wready(wrd), .wdata(ad), .wstrb(4'hf), .bvalid(bv),
    .bready(br), .bresp(bsp), .arvalid(arv), .arready(arr), .araddr(aa), .rvalid(rv),
    .rready(rr), .rdata(rdat), .rresp(rsp), .link(link.part));
  spi_port_assertions u_spi_port_assertions (.clock(clock), .rst_n(rst_n),
    .dev_sck_oe(link.dev_sck_oe), .dev_mosi_oe(link.dev_mosi_oe),
    .dev_miso_oe(link.dev_miso_oe), .part_sck_o(link.part_sck_o),
    .part_sck_oe(link.part_sck_oe), .part_miso_oe(link.part_miso_oe), .ss_n(link.ss_n));
  always #5 clock = ~clock;
  task give_verdict;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task dwr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clock);
    ra <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clock);
    wr <= 1'h0;
  endtask : dwr
  task drd(input logic [1:0] a, input logic [7:0] e);
    @(posedge clock);
    ra <= a;
    rd <= 1'h1;
    @(posedge clock);
    rd <= 1'h0;
    @(posedge clock);
    chk(rdo, e);
  endtask : drd
  // Each channel is released at its own ready
  task axw(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    aa <= a;
    ad <= d;
    awv <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    do
    begin
      @(posedge clock);
      if (awr)
        awv <= 1'h0;
      if (wrd)
        wv <= 1'h0;
    end while (awv && !awr || wv && !wrd);
    @(posedge clock iff bv);
    br <= 1'h0;
    chk(bsp, spi_port_pkg::RESP_OKAY);
  endtask : axw
  task axr(input logic [3:0] a);
    @(posedge clock);
    aa <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    @(posedge clock iff arr);
    arv <= 1'h0;
    @(posedge clock iff rv);
    rr <= 1'h0;
    r = rdat;
    rs = rsp;
  endtask : axr
  // Wire monitor: sck toggles, their spacing, mosi at sample edges; run limit
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    sp <= link.sck;
    gap <= gap + 1;
    if (link.sck !== sp)
    begin
      span <= span + (nt != 0 ? gap : 0);
      nt <= nt + 1;
      gap <= 1;
      if (link.sck === smp)
        cap <= lsb ? {link.mosi, cap[7:1]} : {cap[6:0], link.mosi};
    end
    if (cyc == 30000)
    begin
      errors++;
      give_verdict();
    end
  end
  // Device as master over every rate, mode and order, then as slave
  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'h1;
    drd(2'h3, 8'h00);
    axr(4'h1);
    chk(rs, spi_port_pkg::RESP_SLVERR);
    for (int i = 0; i < 8; i++)
    begin
      h = dv[i % 4] / (i < 4 ? 2 : 4);
      td = 8'hc3 ^ 8'(i * 37);
      smp <= ~(i[0] ^ i[1]);
      lsb <= i[2];
      dwr(spi_port_pkg::ADDR_STATUS, {7'h00, i[2]});
      dwr(spi_port_pkg::ADDR_CTRL, {2'h3, i[2], 1'h1, i[0], i[1], i[1:0]});
      repeat (3) @(posedge clock);
      @(negedge clock);
      nt = 0;
      span = 0;
      dwr(spi_port_pkg::ADDR_DATA, td);
      dwr(spi_port_pkg::ADDR_DATA, ~td);
      for (k = 0; k < 3000 && irq !== 1'h1; k++) @(posedge clock);
      // Let the monitor book the final toggle first
      @(negedge clock);
      chk(irq, 1'h1);
      chk(cap, td);
      chk(nt, 16);
      chk(span, 15 * h);
      drd(spi_port_pkg::ADDR_STATUS, {2'h3, 5'h00, i[2]});
      drd(spi_port_pkg::ADDR_DATA, 8'hff);
      drd(spi_port_pkg::ADDR_STATUS, {7'h00, i[2]});
      chk(irq, 1'h0);
    end
    pr <= 1'h1;
    dwr(spi_port_pkg::ADDR_DATA, 8'h5a);
    chk(link.dev_sck_oe, 1'h0);
    pr <= 1'h0;
    dir <= 4'h0;
    dwr(spi_port_pkg::ADDR_CTRL, 8'hd0);
    dwr(spi_port_pkg::ADDR_STATUS, 8'h00);
    axw(spi_port_pkg::P_CTRL, 32'h0000_0801);
    repeat (8) @(posedge clock);
    drd(spi_port_pkg::ADDR_CTRL, 8'hc0);
    drd(spi_port_pkg::ADDR_STATUS, 8'h80);
    drd(spi_port_pkg::ADDR_DATA, 8'hff);
    dwr(spi_port_pkg::ADDR_DATA, 8'h96);
    dir <= 4'h4;
    axw(spi_port_pkg::P_TX, 32'h0000_003c);
    for (k = 0; k < 3000 && irq !== 1'h1; k++) @(posedge clock);
    chk(irq, 1'h1);
    repeat (40) @(posedge clock);
    drd(spi_port_pkg::ADDR_DATA, 8'h3c);
    axr(spi_port_pkg::P_RX);
    chk(r[7:0], 8'h96);
    axw(spi_port_pkg::P_CTRL, 32'h0000_0811);
    repeat (10) @(posedge clock);
    give_verdict();
  end
endmodule : tb_spi_master_slave_port
